// [hw/drive_config_regs.vh]
// Register map, reset values, field positions and timing for the drive configuration bank.
// Assumes inclusion by bare name from the design files of this bank.
`ifndef DRIVE_CONFIG_REGS_VH
`define DRIVE_CONFIG_REGS_VH

// Register offsets on the object access port.
`define STEP_COUNT_MULTIPLIER_OFFSET   16'h2057
`define STEP_COUNT_DIVIDER_OFFSET      16'h2058
`define ENCODER_SETUP_OFFSET           16'h2059
`define ENCODER_BOOT_POSITION_OFFSET   16'h205A
`define STEP_INPUT_MODE_SELECT_OFFSET  16'h205B
`define BOOT_DELAY_MS_OFFSET           16'h2084
`define FIELDBUS_AVAILABILITY_OFFSET   16'h2101
`define FIELDBUS_ENABLE_CONTROL_OFFSET 16'h2102
`define FIELDBUS_ACTIVE_STATUS_OFFSET  16'h2103

// Reset values.
`define STEP_COUNT_MULTIPLIER_RESET    32'h00000080
`define STEP_COUNT_DIVIDER_RESET       32'h00000001
`define ENCODER_SETUP_RESET            32'h00000000
`define ENCODER_BOOT_POSITION_RESET    32'h00000000
`define STEP_INPUT_MODE_SELECT_RESET   32'h00000000
`define BOOT_DELAY_MS_RESET            32'h00000000
`define FIELDBUS_ENABLE_CONTROL_RESET  32'h00040010

// Encoder setup fields.
`define ENCODER_SUPPLY_SELECT_BIT      0
`define ENCODER_TYPE_SELECT_BIT        1

// Step input mode select field.
`define STEP_MODE_BIT                  0

// Fieldbus bit map shared by availability, control and status.
`define USB_PHYS_BIT                   0
`define RS485_PHYS_BIT                 1
`define RS232_PHYS_BIT                 2
`define CAN_PHYS_BIT                   3
`define ETHERNET_PHYS_BIT              4
`define INDUSTRIAL_ETHER_PHYS_BIT      5
`define SPI_PHYS_BIT                   6
`define SERIAL_REG_PROTOCOL_BIT        16
`define TCP_REG_PROTOCOL_BIT           17
`define INDUSTRIAL_IP_PROTOCOL_BIT     18

// Timing of the boot-up delay.
`define CLK_PERIOD_NS                  40
`define BOOT_TICK_NS                   1000000

`endif

// [hw/step_scaler.v]
// Scales the accumulated step count by the multiplier and the divider.
// Assumes count and settings come from logic on the same clock.
`timescale 1ns/100ps
module step_scaler #(
	parameter WIDTH = 32
) (
	input  wire                    clk,
	input  wire                    rst_n,
	input  wire signed [WIDTH-1:0] raw_count,
	input  wire signed [WIDTH-1:0] multiplier,
	input  wire signed [WIDTH-1:0] divider,
	output reg  signed [WIDTH-1:0] scaled_count
);

	wire signed [2*WIDTH-1:0] product;
	wire signed [2*WIDTH-1:0] wide_divider;
	wire signed [2*WIDTH-1:0] quotient;

	// Multiply first so that the divider does not lose resolution.
	assign product      = raw_count * multiplier;
	assign wide_divider = {{WIDTH{divider[WIDTH-1]}}, divider};
	assign quotient     = (divider == {WIDTH{1'b0}}) ? product : product / wide_divider;

	// A zero divider would be undefined, so the last result is held.
	always @(posedge clk) begin
		if (!rst_n) begin
			scaled_count <= {WIDTH{1'b0}};
		end else if (divider != {WIDTH{1'b0}}) begin
			scaled_count <= quotient[WIDTH-1:0];
		end
	end

endmodule // step_scaler

// [hw/boot_delay_timer.v]
// Counts milliseconds after reset and raises readiness once the delay has passed.
// Assumes the delay setting comes from logic on the same clock.
`timescale 1ns/100ps
module boot_delay_timer #(
	parameter MS_CYCLES = 25000
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [31:0] delay_ms,
	output reg         ready
);

	reg [31:0] cycle_count;
	reg [31:0] ms_count;

	// Cycle prescaler and millisecond counter run until readiness is reached.
	always @(posedge clk) begin
		if (!rst_n) begin
			cycle_count <= 32'h00000000;
			ms_count    <= 32'h00000000;
			ready       <= 1'b0;
		end else if (!ready) begin
			if (ms_count >= delay_ms) begin
				ready <= 1'b1;
			end else if (cycle_count == MS_CYCLES - 1) begin
				cycle_count <= 32'h00000000;
				ms_count    <= ms_count + 32'h00000001;
			end else begin
				cycle_count <= cycle_count + 32'h00000001;
			end
		end
	end

endmodule // boot_delay_timer

// [hw/drive_config_object_bank.v]
// Configuration object bank of a motor controller: step input scaling and mode,
// encoder setup, boot position, boot-up delay and fieldbus selection.
// Assumes a plain register port on clk, step pins from outside the clock domain,
// and encoder and fieldbus information from logic on the same clock.
//
// How it works
// - Accumulated step count is multiplied by the signed multiplier, reset 128.
// - The product is divided by the signed divider, reset one.
// - Encoder setup bit 0 picks supply: 0 is 5 V, 1 is 24 V.
// - Encoder setup bit 1 picks inputs: 0 differential, 1 single-ended.
// - Absolute encoder position is captured once after power-on, read-only.
// - Without an absolute encoder the boot position reads zero.
// - Mode select 0 is pulse plus direction, 1 is clockwise/counter pulses.
// - Readiness waits the boot delay in milliseconds after power-on, reset zero.
// - Availability bits 0 to 15 are interfaces, 16 to 31 protocols.
// - An interface bit reads one when that interface is present.
// - A protocol bit reads one when that protocol is in use.
// - Software writes the control word to switch fieldbuses, reset 0x00040010.
// - Only masked bits switch; the active set shows in a status word.
// - Control and status share one bit map of interfaces and protocols.
// - A mask bit of one means that fieldbus may be switched.
// - A status bit of one means that fieldbus is active.
`timescale 1ns/100ps
`include "drive_config_regs.vh"
module drive_config_object_bank #(
	parameter MS_CYCLES = `BOOT_TICK_NS / `CLK_PERIOD_NS
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [15:0] addr,
	input  wire [31:0] wr_data,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [31:0] rd_data,
	output reg         write_ignored,
	input  wire        step_pin_a,
	input  wire        step_pin_b,
	input  wire        abs_encoder_used,
	input  wire        abs_position_valid,
	input  wire [31:0] abs_position,
	input  wire [15:0] phys_present,
	input  wire [31:0] switch_mask,
	output wire        encoder_supply_select,
	output wire        encoder_single_ended,
	output wire        step_cw_ccw_mode,
	output reg  [31:0] step_count,
	output wire [31:0] scaled_step_count,
	output wire        drive_ready,
	output reg  [31:0] fieldbus_active
);

	// Bits of the fieldbus map that exist in this bank.
	localparam [31:0] fb_impl =
		(32'h00000001 << `USB_PHYS_BIT) |
		(32'h00000001 << `RS485_PHYS_BIT) |
		(32'h00000001 << `RS232_PHYS_BIT) |
		(32'h00000001 << `CAN_PHYS_BIT) |
		(32'h00000001 << `ETHERNET_PHYS_BIT) |
		(32'h00000001 << `INDUSTRIAL_ETHER_PHYS_BIT) |
		(32'h00000001 << `SPI_PHYS_BIT) |
		(32'h00000001 << `SERIAL_REG_PROTOCOL_BIT) |
		(32'h00000001 << `TCP_REG_PROTOCOL_BIT) |
		(32'h00000001 << `INDUSTRIAL_IP_PROTOCOL_BIT);

	// Boot capture states.
	localparam [1:0] cap_strap = 2'b00;
	localparam [1:0] cap_wait  = 2'b01;
	localparam [1:0] cap_done  = 2'b10;

	// Reset values at full width, cut to the fields that hold them below.
	localparam [31:0] encoder_setup_init = `ENCODER_SETUP_RESET;
	localparam [31:0] step_mode_init     = `STEP_INPUT_MODE_SELECT_RESET;

	reg  [31:0] step_count_multiplier;
	reg  [31:0] step_count_divider;
	reg  [1:0]  encoder_setup;
	reg  [31:0] encoder_boot_position;
	reg         step_input_mode_select;
	reg  [31:0] boot_delay_ms;
	reg  [31:0] fieldbus_enable_control;
	reg  [1:0]  cap_state;
	reg  [1:0]  next_cap_state;
	reg         abs_used;
	reg  [1:0]  pin_meta;
	reg  [1:0]  pin_sync;
	reg  [1:0]  pin_prev;
	reg  [31:0] next_step_count;
	reg  [31:0] next_rd_data;
	reg         ro_hit;
	wire [1:0]  pin_rise;
	wire [31:0] switchable;
	wire [31:0] fieldbus_availability;
	wire [31:0] next_active;
	wire [31:0] boot_position_view;
	wire        wr_multiplier;
	wire        wr_divider;
	wire        wr_encoder;
	wire        wr_mode;
	wire        wr_delay;
	wire        wr_control;

	// Write decode for the writable registers.
	assign wr_multiplier = wr_en && (addr == `STEP_COUNT_MULTIPLIER_OFFSET);
	assign wr_divider    = wr_en && (addr == `STEP_COUNT_DIVIDER_OFFSET);
	assign wr_encoder    = wr_en && (addr == `ENCODER_SETUP_OFFSET);
	assign wr_mode       = wr_en && (addr == `STEP_INPUT_MODE_SELECT_OFFSET);
	assign wr_delay      = wr_en && (addr == `BOOT_DELAY_MS_OFFSET);
	assign wr_control    = wr_en && (addr == `FIELDBUS_ENABLE_CONTROL_OFFSET);

	// Step scaling settings, signed, stored whole.
	always @(posedge clk) begin
		if (!rst_n) begin
			step_count_multiplier <= `STEP_COUNT_MULTIPLIER_RESET;
			step_count_divider    <= `STEP_COUNT_DIVIDER_RESET;
		end else begin
			if (wr_multiplier) begin
				step_count_multiplier <= wr_data;
			end
			if (wr_divider) begin
				step_count_divider <= wr_data;
			end
		end
	end

	// Encoder setup keeps only its two defined bits.
	always @(posedge clk) begin
		if (!rst_n) begin
			encoder_setup <= encoder_setup_init[1:0];
		end else if (wr_encoder) begin
			encoder_setup <= wr_data[1:0];
		end
	end

	// Encoder supply and input type drive the encoder front end.
	assign encoder_supply_select = encoder_setup[`ENCODER_SUPPLY_SELECT_BIT];
	assign encoder_single_ended  = encoder_setup[`ENCODER_TYPE_SELECT_BIT];

	// Step mode select and boot delay setting.
	always @(posedge clk) begin
		if (!rst_n) begin
			step_input_mode_select <= step_mode_init[`STEP_MODE_BIT];
			boot_delay_ms          <= `BOOT_DELAY_MS_RESET;
		end else begin
			if (wr_mode) begin
				step_input_mode_select <= wr_data[`STEP_MODE_BIT];
			end
			if (wr_delay) begin
				boot_delay_ms <= wr_data;
			end
		end
	end

	// The mode select bit tells the counter how to read the two step pins.
	assign step_cw_ccw_mode = step_input_mode_select;

	// Step pins pass two flip-flops before any logic looks at them.
	always @(posedge clk) begin
		if (!rst_n) begin
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
			pin_prev <= 2'h0;
		end else begin
			pin_meta <= {step_pin_b, step_pin_a};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Rising edges of the synchronised pins.
	assign pin_rise = pin_sync & ~pin_prev;

	// Counting depends on the mode: pin b is direction, or the reverse pulse.
	// Two rises in one cycle in the two-pulse mode cancel and leave the count.
	always @* begin
		next_step_count = step_count;
		if (!step_input_mode_select) begin
			if (pin_rise[0]) begin
				if (pin_sync[1]) begin
					next_step_count = step_count - 32'h00000001;
				end else begin
					next_step_count = step_count + 32'h00000001;
				end
			end
		end else begin
			case (pin_rise)
				2'b01: next_step_count = step_count + 32'h00000001;
				2'b10: next_step_count = step_count - 32'h00000001;
				default: next_step_count = step_count;
			endcase
		end
	end

	// Accumulated raw step count.
	always @(posedge clk) begin
		if (!rst_n) begin
			step_count <= 32'h00000000;
		end else begin
			step_count <= next_step_count;
		end
	end

	// Multiply then divide the raw count before it is used further.
	// A divider of zero holds the last scaled value instead of dividing.
	step_scaler #(
		.WIDTH (32)
	) u_step_scaler (
		.clk          (clk),
		.rst_n        (rst_n),
		.raw_count    (step_count),
		.multiplier   (step_count_multiplier),
		.divider      (step_count_divider),
		.scaled_count (scaled_step_count)
	);

	// Boot capture: strap first, then one valid position, then frozen.
	always @* begin
		next_cap_state = cap_state;
		case (cap_state)
			cap_strap: begin
				if (abs_encoder_used) begin
					next_cap_state = cap_wait;
				end else begin
					next_cap_state = cap_done;
				end
			end
			cap_wait: begin
				if (abs_position_valid) begin
					next_cap_state = cap_done;
				end
			end
			cap_done: next_cap_state = cap_done;
			default: next_cap_state = cap_strap;
		endcase
	end

	// Strap and position are taken after reset release, never during it.
	always @(posedge clk) begin
		if (!rst_n) begin
			cap_state             <= cap_strap;
			abs_used              <= 1'b0;
			encoder_boot_position <= `ENCODER_BOOT_POSITION_RESET;
		end else begin
			cap_state <= next_cap_state;
			if (cap_state == cap_strap) begin
				abs_used <= abs_encoder_used;
			end
			if ((cap_state == cap_wait) && abs_position_valid) begin
				encoder_boot_position <= abs_position;
			end
		end
	end

	// The boot position is zero unless an absolute encoder is in use.
	assign boot_position_view = abs_used ? encoder_boot_position : 32'h00000000;

	// Readiness follows the boot delay after power-on.
	// The delay is compared live, so only a setting present before readiness counts.
	boot_delay_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_boot_delay_timer (
		.clk      (clk),
		.rst_n    (rst_n),
		.delay_ms (boot_delay_ms),
		.ready    (drive_ready)
	);

	// Only switchable, existing bits may be changed by software.
	assign switchable = switch_mask & fb_impl;

	// Control word merges written bits under the mask with held bits elsewhere.
	always @(posedge clk) begin
		if (!rst_n) begin
			fieldbus_enable_control <= `FIELDBUS_ENABLE_CONTROL_RESET;
		end else if (wr_control) begin
			fieldbus_enable_control <= (fieldbus_enable_control & ~switchable) |
				(wr_data & switchable);
		end
	end

	// An interface is active when enabled and present; protocols when enabled.
	assign next_active = fieldbus_enable_control & fb_impl &
		{16'hFFFF, phys_present};

	// Active set registered for the status word and the fieldbus logic.
	always @(posedge clk) begin
		if (!rst_n) begin
			fieldbus_active <= `FIELDBUS_ENABLE_CONTROL_RESET;
		end else begin
			fieldbus_active <= next_active;
		end
	end

	// Availability: low half is presence, high half the protocol in use.
	assign fieldbus_availability = {fieldbus_active[31:16], phys_present};

	// Read multiplexer; unmapped addresses read zero.
	always @* begin
		next_rd_data = 32'h00000000;
		case (addr)
			`STEP_COUNT_MULTIPLIER_OFFSET:   next_rd_data = step_count_multiplier;
			`STEP_COUNT_DIVIDER_OFFSET:      next_rd_data = step_count_divider;
			`ENCODER_SETUP_OFFSET:           next_rd_data = {30'h00000000, encoder_setup};
			`ENCODER_BOOT_POSITION_OFFSET:   next_rd_data = boot_position_view;
			`STEP_INPUT_MODE_SELECT_OFFSET:
				next_rd_data = {31'h00000000, step_input_mode_select};
			`BOOT_DELAY_MS_OFFSET:           next_rd_data = boot_delay_ms;
			`FIELDBUS_AVAILABILITY_OFFSET:
				next_rd_data = fieldbus_availability;
			`FIELDBUS_ENABLE_CONTROL_OFFSET: next_rd_data = fieldbus_enable_control;
			`FIELDBUS_ACTIVE_STATUS_OFFSET:  next_rd_data = fieldbus_active;
			default:                         next_rd_data = 32'h00000000;
		endcase
	end

	// Writes that land on a read-only or unmapped address.
	// Such writes change nothing; the flag only tells software the write was dropped.
	always @* begin
		ro_hit = 1'b1;
		case (addr)
			`STEP_COUNT_MULTIPLIER_OFFSET:   ro_hit = 1'b0;
			`STEP_COUNT_DIVIDER_OFFSET:      ro_hit = 1'b0;
			`ENCODER_SETUP_OFFSET:           ro_hit = 1'b0;
			`STEP_INPUT_MODE_SELECT_OFFSET:  ro_hit = 1'b0;
			`BOOT_DELAY_MS_OFFSET:           ro_hit = 1'b0;
			`FIELDBUS_ENABLE_CONTROL_OFFSET: ro_hit = 1'b0;
			default:                         ro_hit = 1'b1;
		endcase
	end

	// Read data stand for the one cycle after the read strobe.
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_data       <= 32'h00000000;
			write_ignored <= 1'b0;
		end else begin
			rd_data       <= rd_en ? next_rd_data : 32'h00000000;
			write_ignored <= wr_en && ro_hit;
		end
	end

endmodule // drive_config_object_bank

// [test/drive_config_checker_properties.sv]
// Port-level assertions for the drive configuration object bank.
// Assumes binding onto drive_config_object_bank, one clock and a synchronous reset.
`timescale 1ns/100ps
`include "drive_config_regs.vh"
module drive_config_checker (
	input logic        clk,
	input logic        rst_n,
	input logic [15:0] addr,
	input logic [31:0] wr_data,
	input logic        wr_en,
	input logic        rd_en,
	input logic [31:0] rd_data,
	input logic        write_ignored,
	input logic        abs_encoder_used,
	input logic [15:0] phys_present,
	input logic        encoder_supply_select,
	input logic        encoder_single_ended,
	input logic        step_cw_ccw_mode,
	input logic [31:0] step_count,
	input logic        drive_ready,
	input logic [31:0] fieldbus_active
);
	localparam logic [31:0] IMPL = 32'h0007007F;
	// Every check samples on the rising edge and sleeps while reset is low.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	supply_follow_a: assert property (wr_en && addr == `ENCODER_SETUP_OFFSET
		|=> encoder_supply_select == $past(wr_data[0])) else $error("Supply select off.");
	type_follow_a: assert property (wr_en && addr == `ENCODER_SETUP_OFFSET
		|=> encoder_single_ended == $past(wr_data[1])) else $error("Encoder type off.");
	mode_follow_a: assert property (wr_en && addr == `STEP_INPUT_MODE_SELECT_OFFSET
		|=> step_cw_ccw_mode == $past(wr_data[0])) else $error("Step mode off.");
	ro_write_flag_a: assert property (wr_en && (addr == `FIELDBUS_AVAILABILITY_OFFSET
		|| addr == `ENCODER_BOOT_POSITION_OFFSET || addr == `FIELDBUS_ACTIVE_STATUS_OFFSET)
		|=> write_ignored) else $error("Read-only write not flagged.");
	step_unit_a: assert property ($past(rst_n) |-> step_count == $past(step_count)
		|| step_count - $past(step_count) == 32'h1 || $past(step_count) - step_count == 32'h1)
		else $error("Step count jumped.");
	active_phys_a: assert property ($past(rst_n)
		|-> (fieldbus_active[15:0] & ~$past(phys_present)) == 16'h0000)
		else $error("Absent interface active.");
	active_map_a: assert property ((fieldbus_active & ~IMPL) == 32'h0)
		else $error("Active bit outside map.");
	avail_read_a: assert property (rd_en && addr == `FIELDBUS_AVAILABILITY_OFFSET
		|=> rd_data == {$past(fieldbus_active[31:16]), $past(phys_present)})
		else $error("Availability word wrong.");
	boot_zero_a: assert property (rd_en && addr == `ENCODER_BOOT_POSITION_OFFSET
		&& !abs_encoder_used |=> rd_data == 32'h0) else $error("Boot position not zero.");
	ready_hold_a: assert property (drive_ready |=> drive_ready)
		else $error("Readiness dropped.");
endmodule // drive_config_checker

bind drive_config_object_bank drive_config_checker u_drive_config_checker (.clk, .rst_n,
	.addr, .wr_data, .wr_en, .rd_en, .rd_data, .write_ignored, .abs_encoder_used,
	.phys_present, .encoder_supply_select, .encoder_single_ended, .step_cw_ccw_mode,
	.step_count, .drive_ready, .fieldbus_active);

// [test/drive_config_object_bank_bench.sv]
// Self-checking bench for the drive configuration object bank.
// Assumes the design and its register header are compiled ahead of it.
`timescale 1ns/100ps
`include "drive_config_regs.vh"
module drive_config_object_bank_bench;
	localparam logic [31:0] IMPL = 32'h0007007F;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wr_data = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        step_pin_a = 1'b0;
	logic        step_pin_b = 1'b0;
	logic        abs_encoder_used = 1'b0;
	logic        abs_position_valid = 1'b0;
	logic [31:0] abs_position = 32'h0;
	logic [15:0] phys_present = 16'h0015;
	logic [31:0] switch_mask = 32'h0;
	logic [31:0] rd_data, step_count, scaled_step_count, fieldbus_active;
	logic        write_ignored, encoder_supply_select, encoder_single_ended;
	logic        step_cw_ccw_mode, drive_ready;
	logic [31:0] seed = 32'hABAEE936;
	logic [31:0] ctl, cnt, r, v, mult, div;
	int          bad_count = 0;
	int          checks = 0;

	drive_config_object_bank #(.MS_CYCLES(4)) u_drive_config_object_bank (.clk, .rst_n,
		.addr, .wr_data, .wr_en, .rd_en, .rd_data, .write_ignored, .step_pin_a,
		.step_pin_b, .abs_encoder_used, .abs_position_valid, .abs_position, .phys_present,
		.switch_mask, .encoder_supply_select, .encoder_single_ended, .step_cw_ccw_mode,
		.step_count, .scaled_step_count, .drive_ready, .fieldbus_active);

	// Free-running 25 MHz clock.
	initial begin
		forever #20 clk = ~clk;
	end

	// Xorshift source with a fixed start, so every run repeats.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected fieldbus words come from the bench's own copy of the control word, scaled counts from its own mult and div.
	function automatic logic [31:0] status_exp();
		return ctl & IMPL & {16'hFFFF, phys_present};
	endfunction
	function automatic logic [31:0] avail_exp();
		return (status_exp() & 32'hFFFF0000) | {16'h0000, phys_present};
	endfunction
	function automatic logic [31:0] scale_exp(input logic [31:0] c);
		return 32'(64'($signed(c)) * 64'($signed(mult)) / 64'($signed(div)));
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Register port cycles: one-cycle strobes, read data in the following cycle.
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clk);
		rst_n <= 1'b0;
		abs_encoder_used <= strap;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		ctl = 32'h00040010;
		cnt = 32'h0;
		#1;
		chk({31'h0, drive_ready}, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		chk({31'h0, drive_ready}, 32'h1);
	endtask

	// Presents a position with a valid pulse, then a second one that must be ignored.
	task automatic boot(input logic [31:0] p);
		@(posedge clk);
		abs_position_valid <= 1'b1;
		abs_position <= p;
		@(posedge clk);
		abs_position <= ~p;
		@(posedge clk);
		abs_position_valid <= 1'b0;
	endtask

	// Pulses that stay high and low for three cycles each, past the synchroniser.
	task automatic pulse(input logic ra, input logic rb);
		@(posedge clk);
		step_pin_a <= ra;
		if (rb) step_pin_b <= 1'b1;
		repeat (3) @(posedge clk);
		step_pin_a <= 1'b0;
		if (rb) step_pin_b <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic fb(input logic [31:0] m, input logic [31:0] d, input logic [15:0] ph);
		@(posedge clk);
		switch_mask <= m;
		phys_present <= ph;
		wr(`FIELDBUS_ENABLE_CONTROL_OFFSET, d);
		ctl = (ctl & ~(m & IMPL)) | (d & m & IMPL);
		rdchk(`FIELDBUS_ENABLE_CONTROL_OFFSET, ctl);
		rdchk(`FIELDBUS_ACTIVE_STATUS_OFFSET, status_exp());
		chk(fieldbus_active, status_exp());
		rdchk(`FIELDBUS_AVAILABILITY_OFFSET, avail_exp());
	endtask

	task automatic final_report();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// The whole run needs well under 5000 cycles.
	initial begin
		#(40 * 5000);
		bad_count++;
		final_report();
	end

	// Main sequence: reset values, fieldbus, read-write fields, read-only places, steps, boot.
	initial begin
		do_reset(1'b0);
		boot(rnd());
		rdchk(`STEP_COUNT_MULTIPLIER_OFFSET, 32'h00000080);
		rdchk(`STEP_COUNT_DIVIDER_OFFSET, 32'h00000001);
		rdchk(`ENCODER_SETUP_OFFSET, 32'h0);
		rdchk(`ENCODER_BOOT_POSITION_OFFSET, 32'h0);
		rdchk(`STEP_INPUT_MODE_SELECT_OFFSET, 32'h0);
		rdchk(`BOOT_DELAY_MS_OFFSET, 32'h0);
		rdchk(`FIELDBUS_AVAILABILITY_OFFSET, {16'h0004, phys_present});
		fb(32'h0, 32'hFFFFFFFF, 16'hFFFF);
		fb(32'hFFFFFFFF, 32'h0, 16'h007F);
		repeat (8) fb(rnd(), rnd(), rnd());
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			wr(`BOOT_DELAY_MS_OFFSET, r);
			rdchk(`BOOT_DELAY_MS_OFFSET, r);
			wr(`ENCODER_SETUP_OFFSET, r & 32'hFFFFFFFC | 32'(k));
			rdchk(`ENCODER_SETUP_OFFSET, 32'(k));
			wr(`STEP_INPUT_MODE_SELECT_OFFSET, 32'(k));
			chk({30'h0, encoder_single_ended, encoder_supply_select}, 32'(k));
			chk({31'h0, step_cw_ccw_mode}, 32'(k & 1));
			wr(`FIELDBUS_AVAILABILITY_OFFSET, r);
			chk({31'h0, write_ignored}, 32'h1);
			wr(16'h2000 + 16'(k), r);
			chk({31'h0, write_ignored}, 32'h1);
			rdchk(16'h2000 + 16'(k), 32'h0);
		end
		rdchk(`FIELDBUS_ACTIVE_STATUS_OFFSET, status_exp());
		mult = 32'hFFFFFFFD;
		div = 32'h00000002;
		wr(`STEP_COUNT_MULTIPLIER_OFFSET, mult);
		wr(`STEP_COUNT_DIVIDER_OFFSET, div);
		wr(`STEP_INPUT_MODE_SELECT_OFFSET, 32'h0);
		for (int k = 0; k < 20; k++) begin
			r = rnd();
			@(posedge clk);
			step_pin_b <= (k < 10) & r[0];
			if (k == 10) wr(`STEP_INPUT_MODE_SELECT_OFFSET, 32'h1);
			if (k < 10) pulse(1'b1, 1'b0);
			else pulse(r[0], r[1]);
			if (k < 10) cnt = r[0] ? cnt - 32'h1 : cnt + 32'h1;
			else cnt = cnt + ((r[1:0] == 2'b01) ? 32'h1 : (r[1:0] == 2'b10) ? '1 : 32'h0);
			chk(step_count, cnt);
			chk(scaled_step_count, scale_exp(cnt));
		end
		v = scale_exp(cnt);
		wr(`STEP_COUNT_DIVIDER_OFFSET, 32'h0);
		pulse(1'b1, 1'b0);
		chk(scaled_step_count, v);
		do_reset(1'b1);
		r = rnd();
		boot(r);
		rdchk(`ENCODER_BOOT_POSITION_OFFSET, r);
		wr(`ENCODER_BOOT_POSITION_OFFSET, ~r);
		chk({31'h0, write_ignored}, 32'h1);
		rdchk(`ENCODER_BOOT_POSITION_OFFSET, r);
		final_report();
	end
endmodule // drive_config_object_bank_bench
